// ### hw/cias_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the alarm/code interrupt block
// Assumes: Register offsets are word indexes; byte address is four times the index
// Notes: Definitions only
`ifndef CIAS_DEFINES_SVH
`define CIAS_DEFINES_SVH

`define CIAS_IDX_CUST_STAT 12'hb40
`define CIAS_IDX_CUST_EN 12'hb41
`define CIAS_IDX_CODE_STAT 12'hb70
`define CIAS_IDX_IRQ_STAT 12'hb78
`define CIAS_IDX_IRQ_CLR 12'hb79
`define CIAS_IDX_IRQ_EN 12'hb7a

`define CIAS_BIT_AIS 1
`define CIAS_BIT_RAI 0

`define CIAS_BIT_MATCH3 7
`define CIAS_BIT_MATCH2 6
`define CIAS_BIT_CLEARED 5
`define CIAS_BIT_ABORT 4
`define CIAS_BIT_RX_FULL 3
`define CIAS_BIT_TX_EMPTY 2
`define CIAS_BIT_MATCH1 1
`define CIAS_BIT_CODE_CHANGE 0

`define CIAS_RST_CUST_STAT 2'h0
`define CIAS_RST_CUST_EN 2'h0
`define CIAS_RST_CODE_STAT 8'h00
`define CIAS_RST_IRQ_EN 8'h00

`define CIAS_NOCODE_LIMIT 3
`define CIAS_ABORT_ONES 9

`endif

// ### hw/cias_pkg.sv
// Purpose: Types and address decode of the alarm/code interrupt block
// Assumes: AHB-Lite word accesses only
// Notes: Constants live in cias_defines.svh
`include "cias_defines.svh"

package cias_pkg;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CUST_STAT,
        SEL_CUST_EN,
        SEL_CODE_STAT,
        SEL_IRQ_STAT,
        SEL_IRQ_CLR,
        SEL_IRQ_EN
    } cias_sel_type;

    typedef struct packed {
        logic [1:0] cust_en;
        logic [7:0] irq_en;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic irq;
        logic wr_pending;
        cias_sel_type wr_sel;
        logic ais_prev;
        logic rai_prev;
        logic [1:0] nocode_cnt;
        logic [3:0] ones_cnt;
    } cias_state_type;

    function automatic cias_sel_type cias_decode(input logic [31:0] addr);
        cias_sel_type sel;
        sel = SEL_NONE;
        if (addr[31:14] == 18'h00000 && addr[1:0] == 2'h0) begin
            unique case (addr[13:2])
                `CIAS_IDX_CUST_STAT: sel = SEL_CUST_STAT;
                `CIAS_IDX_CUST_EN: sel = SEL_CUST_EN;
                `CIAS_IDX_CODE_STAT: sel = SEL_CODE_STAT;
                `CIAS_IDX_IRQ_STAT: sel = SEL_IRQ_STAT;
                `CIAS_IDX_IRQ_CLR: sel = SEL_IRQ_CLR;
                `CIAS_IDX_IRQ_EN: sel = SEL_IRQ_EN;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

endpackage

// ### hw/cias_flag_if.sv
// Purpose: Set, clear and flag vectors between the top and a sticky flag bank
// Assumes: One clock domain
// Notes: Width is a parameter
`timescale 1ns/1ns

interface cias_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    modport owner(input set, input clr, output flags);
    modport user(output set, output clr, input flags);
endinterface

// ### hw/cias_flags.sv
// Purpose: Bank of sticky flags, set by events, cleared by a clear vector
// Assumes: Synchronous active-high reset
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ns

module cias_flags
    import cias_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic reset,
    cias_flag_if.owner port
);

    typedef struct packed {
        logic [W-1:0] flags;
    } cias_flag_state_type;

    cias_flag_state_type s;
    cias_flag_state_type next_s;
    logic [W-1:0] clr_only;

    if (W < 1 || W > 32) begin : g_bad_width
        $error("cias_flags: width must be 1 to 32");
    end

    always_comb begin
        next_s.flags = (s.flags & ~port.clr) | port.set;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign port.flags = s.flags;
    assign clr_only = port.clr & ~port.set;

    a_set_wins: assert property (@(posedge clock) disable iff (reset)
        (|port.set) |=> ((port.flags & $past(port.set)) == $past(port.set)))
        else $error("flag event lost");

    a_clear_drops: assert property (@(posedge clock) disable iff (reset)
        (|clr_only) |=> ((port.flags & $past(clr_only)) == '0))
        else $error("cleared flag still set");

endmodule

// ### hw/cias_top.sv
// Purpose: Customer alarm change flags, code event flags and interrupt output, AHB-Lite slave
// Assumes: 20 MHz clock, synchronous active-high reset, inputs synchronous to clock
// Notes: Zero wait states; read data come from a register set at the address phase
`timescale 1ns/1ns
`include "cias_defines.svh"

// Notes on behaviour
// - Alarm-indication start or stop sets bit 1
// - Remote-alarm declare or clear sets bit 0
// - Flags show changes since last read; read clears
// - Alarm-indication interrupt only when enable bit 1
// - Remote-alarm interrupt only when enable bit 0
// - Eight-bit code event register, cleared on read
// - Three framed messages without code: code cleared
// - Nine consecutive link ones: link abort event
// - Alarm-indication level comes from signature detector
// - Remote alarm counts only in extended superframe
module cias_top
    import cias_pkg::*;
#(
    parameter int NOCODE_LIMIT = `CIAS_NOCODE_LIMIT,
    parameter int ABORT_ONES = `CIAS_ABORT_ONES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic customer_alarm_indication,
    input wire logic customer_remote_alarm,
    input wire logic esf_mode,
    input wire logic msg_valid,
    input wire logic msg_framed,
    input wire logic msg_has_code,
    input wire logic link_bit_valid,
    input wire logic link_bit,
    input wire logic [7:0] code_events_in,
    output logic irq
);

    localparam logic [1:0] NOCODE_LAST = 2'(NOCODE_LIMIT - 1);
    localparam logic [3:0] ABORT_LAST = 4'(ABORT_ONES - 1);
    localparam cias_state_type RESET_STATE = '{
        cust_en: `CIAS_RST_CUST_EN,
        irq_en: `CIAS_RST_IRQ_EN,
        hrdata: 32'h00000000,
        hreadyout: 1'b1,
        hresp: 1'b0,
        irq: 1'b0,
        wr_pending: 1'b0,
        wr_sel: SEL_NONE,
        ais_prev: 1'b0,
        rai_prev: 1'b0,
        nocode_cnt: 2'h0,
        ones_cnt: 4'h0
    };

    if (NOCODE_LIMIT < 1 || NOCODE_LIMIT > 3) begin : g_bad_nocode
        $error("cias_top: NOCODE_LIMIT must be 1 to 3");
    end
    if (ABORT_ONES < 1 || ABORT_ONES > 15) begin : g_bad_abort
        $error("cias_top: ABORT_ONES must be 1 to 15");
    end

    cias_state_type s;
    cias_state_type next_s;
    logic addr_ok;
    logic rd_phase;
    cias_sel_type sel;
    logic irq_cause;

    cias_flag_if #(.W(2)) cust_if();
    cias_flag_if #(.W(8)) code_if();
    cias_flag_if #(.W(8)) pend_if();

    cias_flags #(.W(2)) u_cust_flags (
        .clock(clock),
        .reset(reset),
        .port(cust_if.owner)
    );

    cias_flags #(.W(8)) u_code_flags (
        .clock(clock),
        .reset(reset),
        .port(code_if.owner)
    );

    cias_flags #(.W(8)) u_pend_flags (
        .clock(clock),
        .reset(reset),
        .port(pend_if.owner)
    );

    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_phase = addr_ok & ~hwrite;
    assign sel = cias_decode(haddr);

    always_comb begin
        logic ais_now;
        logic rai_now;
        logic nocode_ev;
        logic abort_ev;
        logic [7:0] ev;
        logic [31:0] rdata;
        logic [1:0] cust_hit;
        ais_now = customer_alarm_indication;
        rai_now = customer_remote_alarm & esf_mode;
        nocode_ev = 1'b0;
        abort_ev = 1'b0;
        ev = 8'h00;
        rdata = 32'h00000000;
        cust_hit = 2'h0;
        next_s = s;

        // Level change in either direction marks a change
        next_s.ais_prev = ais_now;
        next_s.rai_prev = rai_now;
        cust_if.set = 2'h0;
        cust_if.set[`CIAS_BIT_AIS] = ais_now ^ s.ais_prev;
        cust_if.set[`CIAS_BIT_RAI] = rai_now ^ s.rai_prev;

        // Framed messages without a valid code, saturating
        if (msg_valid) begin
            if (msg_framed && !msg_has_code) begin
                if (s.nocode_cnt < NOCODE_LAST) begin
                    next_s.nocode_cnt = s.nocode_cnt + 2'h1;
                end else if (s.nocode_cnt == NOCODE_LAST) begin
                    next_s.nocode_cnt = s.nocode_cnt + 2'h1;
                    nocode_ev = 1'b1;
                end
            end else begin
                next_s.nocode_cnt = 2'h0;
            end
        end

        // Run of ones on the link, saturating
        if (link_bit_valid) begin
            if (link_bit) begin
                if (s.ones_cnt < ABORT_LAST) begin
                    next_s.ones_cnt = s.ones_cnt + 4'h1;
                end else if (s.ones_cnt == ABORT_LAST) begin
                    next_s.ones_cnt = s.ones_cnt + 4'h1;
                    abort_ev = 1'b1;
                end
            end else begin
                next_s.ones_cnt = 4'h0;
            end
        end

        ev = code_events_in;
        ev[`CIAS_BIT_CLEARED] = code_events_in[`CIAS_BIT_CLEARED] | nocode_ev;
        ev[`CIAS_BIT_ABORT] = code_events_in[`CIAS_BIT_ABORT] | abort_ev;
        code_if.set = ev;
        pend_if.set = ev;

        // Read side effects happen at the address phase
        unique case (sel)
            SEL_CUST_STAT: rdata = {30'h00000000, cust_if.flags};
            SEL_CUST_EN: rdata = {30'h00000000, s.cust_en};
            SEL_CODE_STAT: rdata = {24'h000000, code_if.flags};
            SEL_IRQ_STAT: rdata = {24'h000000, pend_if.flags};
            SEL_IRQ_EN: rdata = {24'h000000, s.irq_en};
            default: rdata = 32'h00000000;
        endcase
        cust_if.clr = (rd_phase && sel == SEL_CUST_STAT) ? 2'h3 : 2'h0;
        code_if.clr = (rd_phase && sel == SEL_CODE_STAT) ? 8'hff : 8'h00;
        if (rd_phase) begin
            next_s.hrdata = rdata;
        end

        // Writes land at the end of the data phase
        pend_if.clr = 8'h00;
        if (s.wr_pending) begin
            unique case (s.wr_sel)
                SEL_CUST_EN: next_s.cust_en = hwdata[1:0];
                SEL_IRQ_CLR: pend_if.clr = hwdata[7:0];
                SEL_IRQ_EN: next_s.irq_en = hwdata[7:0];
                default: next_s.cust_en = s.cust_en;
            endcase
        end
        next_s.wr_pending = addr_ok & hwrite;
        next_s.wr_sel = addr_ok ? sel : SEL_NONE;

        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
        cust_hit[`CIAS_BIT_AIS] = cust_if.flags[`CIAS_BIT_AIS] & s.cust_en[`CIAS_BIT_AIS];
        cust_hit[`CIAS_BIT_RAI] = cust_if.flags[`CIAS_BIT_RAI] & s.cust_en[`CIAS_BIT_RAI];
        irq_cause = (|cust_hit) | (|(pend_if.flags & s.irq_en));
        next_s.irq = irq_cause;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign irq = s.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_ais_change: assert property (
        $changed(customer_alarm_indication) |=> cust_if.flags[`CIAS_BIT_AIS])
        else $error("alarm-indication change not flagged");

    a_rai_change: assert property (
        esf_mode && $past(esf_mode) && $changed(customer_remote_alarm)
        |=> cust_if.flags[`CIAS_BIT_RAI])
        else $error("remote-alarm change not flagged");

    a_rai_esf_only: assert property (
        !esf_mode && !$past(esf_mode) && !cust_if.flags[`CIAS_BIT_RAI]
        |=> !cust_if.flags[`CIAS_BIT_RAI])
        else $error("remote-alarm flagged outside extended superframe");

    a_read_returns: assert property (
        rd_phase && sel == SEL_CUST_STAT
        |=> hrdata == {30'h00000000, $past(cust_if.flags)})
        else $error("status read returned wrong flags");

    a_read_clears: assert property (
        rd_phase && sel == SEL_CUST_STAT && cust_if.set == 2'h0
        |=> cust_if.flags == 2'h0)
        else $error("status read did not clear flags");

    a_ais_gate: assert property (
        cust_if.flags[`CIAS_BIT_AIS] && s.cust_en[`CIAS_BIT_AIS] |=> irq)
        else $error("enabled alarm-indication change gave no interrupt");

    a_rai_gate: assert property (
        cust_if.flags[`CIAS_BIT_RAI] && s.cust_en[`CIAS_BIT_RAI] |=> irq)
        else $error("enabled remote-alarm change gave no interrupt");

    a_code_layout: assert property (
        code_events_in[`CIAS_BIT_MATCH3] && code_events_in[`CIAS_BIT_CODE_CHANGE]
        |=> code_if.flags[`CIAS_BIT_MATCH3] && code_if.flags[`CIAS_BIT_CODE_CHANGE])
        else $error("code event landed in wrong bit");

    a_code_cleared: assert property (
        msg_valid && msg_framed && !msg_has_code && s.nocode_cnt == NOCODE_LAST
        |=> code_if.flags[`CIAS_BIT_CLEARED] && pend_if.flags[`CIAS_BIT_CLEARED])
        else $error("missing code-cleared event");

    a_link_abort: assert property (
        link_bit_valid && link_bit && s.ones_cnt == ABORT_LAST
        |=> code_if.flags[`CIAS_BIT_ABORT])
        else $error("missing link abort event");

    a_irq_cause: assert property (
        irq |-> $past(irq_cause))
        else $error("interrupt without enabled flag");

    a_irq_drop: assert property (
        !irq_cause |=> !irq)
        else $error("interrupt stayed high without enabled flag");

    a_code_read_returns: assert property (
        rd_phase && sel == SEL_CODE_STAT
        |=> hrdata == {24'h000000, $past(code_if.flags)})
        else $error("code status read returned wrong flags");

    a_code_read_clears: assert property (
        rd_phase && sel == SEL_CODE_STAT && code_if.set == 8'h00
        |=> code_if.flags == 8'h00)
        else $error("code status read did not clear flags");

    a_cust_keep: assert property (
        !(rd_phase && sel == SEL_CUST_STAT)
        |=> (cust_if.flags & $past(cust_if.flags)) == $past(cust_if.flags))
        else $error("change flag lost without a read");

    a_code_keep: assert property (
        !(rd_phase && sel == SEL_CODE_STAT)
        |=> (code_if.flags & $past(code_if.flags)) == $past(code_if.flags))
        else $error("code flag lost without a read");

    a_ais_quiet: assert property (
        !$past(reset) && $stable(customer_alarm_indication) && !cust_if.flags[`CIAS_BIT_AIS]
        |=> !cust_if.flags[`CIAS_BIT_AIS])
        else $error("alarm-indication flagged without change");

    a_rai_quiet: assert property (
        !$past(reset) && $stable(customer_remote_alarm) && $stable(esf_mode)
        && !cust_if.flags[`CIAS_BIT_RAI]
        |=> !cust_if.flags[`CIAS_BIT_RAI])
        else $error("remote-alarm flagged without change");

    a_nocode_early: assert property (
        s.nocode_cnt != NOCODE_LAST && !code_events_in[`CIAS_BIT_CLEARED]
        && !code_if.flags[`CIAS_BIT_CLEARED]
        |=> !code_if.flags[`CIAS_BIT_CLEARED])
        else $error("code-cleared event too early");

    a_abort_early: assert property (
        s.ones_cnt != ABORT_LAST && !code_events_in[`CIAS_BIT_ABORT]
        && !code_if.flags[`CIAS_BIT_ABORT]
        |=> !code_if.flags[`CIAS_BIT_ABORT])
        else $error("link abort event too early");

    a_en_write: assert property (
        s.wr_pending && s.wr_sel == SEL_CUST_EN
        |=> {30'h00000000, s.cust_en} == ($past(hwdata) & 32'h00000003))
        else $error("enable write did not land");

    a_pend_sticky: assert property (
        !(s.wr_pending && s.wr_sel == SEL_IRQ_CLR)
        |=> (pend_if.flags & $past(pend_if.flags)) == $past(pend_if.flags))
        else $error("pending flag lost without a clear");

    a_pend_set: assert property (
        code_events_in != 8'h00
        |=> (pend_if.flags & $past(code_events_in)) == $past(code_events_in))
        else $error("code event not pending");

    a_rd_hold: assert property (
        !rd_phase |=> $stable(hrdata))
        else $error("read data changed without a read");

    a_bus_okay: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered error");

    c_ais_read: cover property (
        cust_if.flags[`CIAS_BIT_AIS] ##1 (rd_phase && sel == SEL_CUST_STAT));
    c_irq_rise: cover property ($rose(irq));
    c_code_cleared: cover property ($rose(code_if.flags[`CIAS_BIT_CLEARED]));
    c_irq_clear: cover property ((s.wr_pending && s.wr_sel == SEL_IRQ_CLR) ##1 !irq);
    c_link_abort: cover property ($rose(code_if.flags[`CIAS_BIT_ABORT]));

endmodule

// ### test/tb_cias_top.sv
// Purpose: Self-checking bench for the alarm change and code event interrupt block
// Assumes: Zero-wait AHB-Lite slave, one clock, flags set one edge after their cause
// Notes: Each scenario is a task that drives the block and judges the answers
`timescale 1ns/1ns
`include "cias_defines.svh"

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s exp %h seen %h", what, exp, got); end end

module tb_cias_top
    import cias_pkg::*;
;
    logic clock, reset, hsel, hwrite, esf_mode, msg_valid, msg_framed, msg_has_code;
    logic customer_alarm_indication, customer_remote_alarm, link_bit_valid, link_bit;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rd;
    logic [7:0] code_events_in;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq, hready;
    int errors, checks;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cias_top cias_top_i (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .customer_alarm_indication(customer_alarm_indication),
        .customer_remote_alarm(customer_remote_alarm), .esf_mode(esf_mode),
        .msg_valid(msg_valid), .msg_framed(msg_framed), .msg_has_code(msg_has_code),
        .link_bit_valid(link_bit_valid), .link_bit(link_bit),
        .code_events_in(code_events_in), .irq(irq));

    always #25 clock = ~clock;

    task summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask

    // One single word transfer; read data taken at the edge ending the data phase
    task bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h00000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp);
    endtask

    task rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h00000000);
        `CHK(what, exp, rd);
    endtask

    // Flag lands one edge after the cause, irq one edge later
    task irq_chk(input logic v, input string what);
        int n;
        n = 0;
        repeat (3) @(posedge clock);
        while (irq !== v && n < 8) begin
            @(posedge clock);
            n++;
        end
        `CHK(what, v, irq);
    endtask

    task lvl(input int which, input logic v);
        @(posedge clock);
        case (which)
            0: customer_alarm_indication <= v;
            1: customer_remote_alarm <= v;
            default: esf_mode <= v;
        endcase
        @(posedge clock);
    endtask

    task pulse_code(input logic [7:0] v);
        @(posedge clock);
        code_events_in <= v;
        @(posedge clock);
        code_events_in <= 8'h00;
    endtask

    task msg(input logic framed, input logic has_code);
        @(posedge clock);
        msg_valid <= 1'b1;
        msg_framed <= framed;
        msg_has_code <= has_code;
        @(posedge clock);
        msg_valid <= 1'b0;
    endtask

    task lbit(input logic b);
        @(posedge clock);
        link_bit_valid <= 1'b1;
        link_bit <= b;
        @(posedge clock);
        link_bit_valid <= 1'b0;
    endtask

    task t_reset;
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h0, "cust status");
        rd_chk(`CIAS_IDX_CUST_EN, 32'h0, "cust enable");
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h0, "code status");
        irq_chk(1'b0, "irq idle");
        $display("test reset done");
    endtask

    task t_alarms;
        lvl(0, 1'b1);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h2, "ais start");
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h0, "ais read clear");
        lvl(0, 1'b0);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h2, "ais stop");
        irq_chk(1'b0, "irq disabled");
        lvl(1, 1'b1);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h1, "rai declare");
        lvl(1, 1'b0);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h1, "rai clear");
        lvl(2, 1'b0);
        lvl(1, 1'b1);
        lvl(1, 1'b0);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h0, "rai outside esf");
        lvl(2, 1'b1);
        $display("test alarms done");
    endtask

    task t_enable;
        bus(1'b1, `CIAS_IDX_CUST_EN, 32'hffffffff);
        rd_chk(`CIAS_IDX_CUST_EN, 32'h3, "enable width");
        bus(1'b1, `CIAS_IDX_CUST_EN, 32'h2);
        lvl(0, 1'b1);
        irq_chk(1'b1, "ais irq");
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h2, "ais flag");
        irq_chk(1'b0, "irq after read");
        bus(1'b1, `CIAS_IDX_CUST_EN, 32'h1);
        lvl(0, 1'b0);
        irq_chk(1'b0, "ais masked");
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h2, "masked flag kept");
        lvl(1, 1'b1);
        irq_chk(1'b1, "rai irq");
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h1, "rai flag");
        irq_chk(1'b0, "irq after rai read");
        lvl(1, 1'b0);
        rd_chk(`CIAS_IDX_CUST_STAT, 32'h1, "rai flag drop");
        bus(1'b1, `CIAS_IDX_CUST_EN, 32'h0);
        $display("test enable done");
    endtask

    task t_codes;
        for (int i = 0; i < 8; i++) begin
            pulse_code(8'h01 << i);
            rd_chk(`CIAS_IDX_CODE_STAT, 32'h1 << i, "code bit");
        end
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h0, "code read clear");
        pulse_code(8'h81);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h81, "code bits 7 and 0");
        msg(1'b1, 1'b0);
        msg(1'b1, 1'b0);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h0, "two no-code");
        msg(1'b1, 1'b0);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h20, "third no-code");
        msg(1'b1, 1'b0);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h0, "fourth no-code");
        msg(1'b1, 1'b1);
        repeat (3) msg(1'b1, 1'b0);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h20, "coded restart");
        msg(1'b0, 1'b0);
        repeat (3) msg(1'b1, 1'b0);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h20, "unframed restart");
        for (int i = 0; i < 8; i++) lbit(1'b1);
        lbit(1'b0);
        for (int i = 0; i < 8; i++) lbit(1'b1);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h0, "eight ones");
        lbit(1'b1);
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h10, "ninth one");
        $display("test codes done");
    endtask

    task t_pending;
        bus(1'b1, `CIAS_IDX_IRQ_CLR, 32'hff);
        rd_chk(`CIAS_IDX_IRQ_STAT, 32'h0, "pending cleared");
        pulse_code(8'h04);
        irq_chk(1'b0, "pending masked");
        rd_chk(`CIAS_IDX_IRQ_STAT, 32'h4, "pending sticky");
        rd_chk(`CIAS_IDX_CODE_STAT, 32'h4, "code tx empty");
        bus(1'b1, `CIAS_IDX_IRQ_EN, 32'h4);
        irq_chk(1'b1, "pending irq");
        bus(1'b1, `CIAS_IDX_IRQ_CLR, 32'h4);
        irq_chk(1'b0, "pending irq clear");
        rd_chk(`CIAS_IDX_IRQ_EN, 32'h4, "pending enable");
        bus(1'b1, `CIAS_IDX_IRQ_EN, 32'h0);
        bus(1'b1, 12'hb42, 32'hffffffff);
        rd_chk(12'hb42, 32'h0, "unmapped read");
        rd_chk(`CIAS_IDX_CUST_EN, 32'h0, "unmapped write");
        $display("test pending done");
    endtask

    initial begin
        clock = 1'b0;
        reset = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        esf_mode = 1'b1;
        msg_valid = 1'b0;
        msg_framed = 1'b0;
        msg_has_code = 1'b0;
        customer_alarm_indication = 1'b0;
        customer_remote_alarm = 1'b0;
        link_bit_valid = 1'b0;
        link_bit = 1'b0;
        code_events_in = 8'h00;
        errors = 0;
        checks = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_alarms();
        t_enable();
        t_codes();
        t_pending();
        summarize();
    end
endmodule
